// file: rtl/trk_gate.sv
// Transmit gating, event counter and profile switching with an APB slave.
// Assumes pclk at 100 MHz; pin inputs are asynchronous, the demodulator,
// modem, ADC and position inputs are logic on pclk.
module trk_gate #(
  parameter int unsigned MS_CYCLES = trk_pkg::MS_CYC,
  parameter int unsigned Q64_CYCLES = trk_pkg::Q64_CYC,
  parameter int unsigned SEC_CYCLES = trk_pkg::SEC_CYC,
  parameter int unsigned BAUD_FAST_CYCLES = trk_pkg::BAUD_FAST_CYC,
  parameter int unsigned BAUD_SLOW_CYCLES = trk_pkg::BAUD_SLOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_in,
  input wire logic squelch_open_input,
  input wire logic event_n,
  input wire logic profile_switch,
  input wire logic mic_ptt_n,
  input wire logic carrier_detect_qualifier,
  input wire logic [7:0] supply_level,
  input wire logic [7:0] adc_level,
  input wire logic fix_pulse,
  input wire logic tx_request,
  input wire logic tx_done,
  output logic ptt_out,
  output logic power_relay,
  output logic data_start,
  output logic profile_sel,
  output logic profile_load,
  output logic tone_en,
  output logic tone_space
);
  import trk_pkg::*;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] quiet;
    logic [7:0] debounce;
    logic [7:0] power_s;
    logic [9:0] txdly;
    logic [7:0] lvmin;
    logic [31:0] prof0;
    logic [31:0] prof1;
    logic [15:0] count;
    logic [7:0] rearm;
    logic ev_last;
    logic mic_last;
    logic [7:0] quiet_cnt;
    logic [9:0] wait_cnt;
    logic pend;
    trk_seq_type seq;
    logic profile;
    logic [4:0] fix_age;
    logic ptt;
    logic relay;
    logic data_go;
    logic prof_load;
    logic tone_on;
    logic tone_sp;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } trk_state_type;

  localparam trk_state_type STATE_RST = '{
    ctrl: CTRL_RST, quiet: QUIET_RST, debounce: DEBOUNCE_RST,
    power_s: POWER_RST, txdly: TXDLY_RST, lvmin: LVMIN_RST,
    prof0: PROF_RST, prof1: PROF_RST, seq: ST_IDLE,
    fix_age: FIX_AGE_RST, sync1: SYNC_RST, sync2: SYNC_RST, default: '0};

  trk_state_type q;
  trk_state_type d;
  trk_tick_if tif ();

  // ****************************************************************
  // Profile condition check
  // ****************************************************************
  function automatic logic cond_met(input logic [31:0] p,
                                    input logic [7:0] adc,
                                    input logic [7:0] volt,
                                    input logic sw_on,
                                    input logic fix_ok);
    logic [3:0] en;
    logic [3:0] op;
    logic [3:0] res;
    logic [7:0] athr;
    logic [7:0] vthr;
    en = p[PB_EN_LSB +: 4];
    op = p[PB_OP_LSB +: 4];
    athr = p[PB_ADC_THR_LSB +: 8];
    vthr = p[PB_VOLT_THR_LSB +: 8];
    res[C_ADC] = op[C_ADC] ? (adc > athr) : (adc <= athr);
    res[C_VOLT] = op[C_VOLT] ? (volt > vthr) : (volt <= vthr);
    res[C_JMP] = (sw_on == op[C_JMP]);
    res[C_FIX] = (fix_ok == op[C_FIX]);
    return (en != 4'h0) && ((res | ~en) == 4'hf);
  endfunction

  trk_tick_div #(
    .MS_CYCLES(MS_CYCLES),
    .Q64_CYCLES(Q64_CYCLES),
    .SEC_CYCLES(SEC_CYCLES),
    .BAUD_FAST_CYCLES(BAUD_FAST_CYCLES),
    .BAUD_SLOW_CYCLES(BAUD_SLOW_CYCLES)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif.gen)
  );

  assign tif.baud_slow = q.ctrl[CB_BAUD300];

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic cd_s;
  logic sq_s;
  logic ev_s_n;
  logic sw_s;
  logic mic_s_n;
  logic sw_used;
  logic cnt_active;
  logic carrier;
  logic busy;
  logic inhibit;
  logic fix_ok;
  logic quiet_ok;
  logic ev_edge;
  logic ev_take;
  logic mic_on;
  logic mic_rel;
  logic sw_go;
  logic req;
  logic taken;
  logic prof_tx;
  logic [15:0] cnt_base;
  logic [31:0] other;
  logic setup;
  logic wr;

  always_comb begin
    d = q;
    d.sync1 = {carrier_in, squelch_open_input, event_n, profile_switch,
               mic_ptt_n};
    d.sync2 = q.sync1;
    {cd_s, sq_s, ev_s_n, sw_s, mic_s_n} = q.sync2;
    d.data_go = 1'b0;
    d.prof_load = 1'b0;
    taken = 1'b0;
    prof_tx = 1'b0;
    setup = psel & ~penable;
    wr = psel & penable & pwrite;
    sw_go = wr & (paddr == ADDR_CTRL) & pwdata[CB_TX_GO];

    // Channel state and inhibit.
    sw_used = q.prof0[PB_EN_LSB + C_JMP] | q.prof1[PB_EN_LSB + C_JMP];
    cnt_active = q.ctrl[CB_CNT_EN] & ~sw_used;
    carrier = q.ctrl[CB_EXTSQL] ? sq_s : (cd_s ^ q.ctrl[CB_CDINV]);
    busy = q.ctrl[CB_SWDCD] ? carrier_detect_qualifier : carrier;
    inhibit = q.ctrl[CB_LOWV] & (supply_level < q.lvmin);
    fix_ok = (q.fix_age <= FIX_TIMEOUT_S);
    if (busy) begin
      d.quiet_cnt = 8'h00;
    end else if (tif.tick_q64 && q.quiet_cnt != 8'hff) begin
      d.quiet_cnt = q.quiet_cnt + 8'h01;
    end
    quiet_ok = ~busy & (q.quiet_cnt >= q.quiet);

    // Position age in seconds, saturating just past the limit.
    if (fix_pulse) begin
      d.fix_age = 5'h00;
    end else if (tif.tick_sec && q.fix_age != FIX_AGE_RST) begin
      d.fix_age = q.fix_age + 5'h01;
    end

    // Event input: grounded means active.
    ev_edge = ~ev_s_n & ~q.ev_last;
    d.ev_last = ~ev_s_n;
    if (q.rearm != 8'h00 && tif.tick_ms) begin
      d.rearm = q.rearm - 8'h01;
    end
    ev_take = ev_edge & (q.rearm == 8'h00);
    mic_on = ~mic_s_n;
    mic_rel = q.mic_last & ~mic_on;
    d.mic_last = mic_on;

    // Once-per-second profile evaluation.
    other = q.profile ? q.prof0 : q.prof1;
    if (tif.tick_sec &&
        cond_met(other, adc_level, supply_level, sw_s, fix_ok)) begin
      d.profile = ~q.profile;
      d.prof_load = 1'b1;
      prof_tx = other[PB_TXSW];
    end

    req = tx_request | sw_go | prof_tx | (q.ctrl[CB_PTTIN] & mic_rel) |
          (ev_take & ~q.ctrl[CB_CNT_EN] & ~sw_used);

    // Transmit sequencer.
    cnt_base = q.count;
    unique case (q.seq)
      ST_IDLE: begin
        if (q.pend && !inhibit) begin
          taken = 1'b1;
          if (q.ctrl[CB_PWR]) begin
            d.relay = 1'b1;
            d.wait_cnt = {2'b00, q.power_s};
            d.seq = ST_POWER;
          end else begin
            d.seq = ST_QUIET;
          end
        end
      end
      ST_POWER: begin
        if (q.wait_cnt == 10'h000) begin
          d.seq = ST_QUIET;
        end else if (tif.tick_sec) begin
          d.wait_cnt = q.wait_cnt - 10'h001;
        end
      end
      ST_QUIET: begin
        if (quiet_ok && !(q.ctrl[CB_PTTIN] && mic_on)) begin
          d.ptt = 1'b1;
          d.wait_cnt = q.txdly;
          d.seq = ST_KEY;
        end
      end
      ST_KEY: begin
        if (q.wait_cnt == 10'h000) begin
          d.data_go = 1'b1;
          d.seq = ST_SEND;
        end else if (tif.tick_ms) begin
          d.wait_cnt = q.wait_cnt - 10'h001;
        end
      end
      ST_SEND: begin
        if (tx_done) begin
          d.ptt = 1'b0;
          d.relay = 1'b0;
          d.seq = ST_IDLE;
          if (q.ctrl[CB_CNT_RST]) begin
            cnt_base = 16'h0000;
          end
        end
      end
      default: begin
        d.seq = ST_IDLE;
      end
    endcase
    if (inhibit && q.seq != ST_IDLE) begin
      d.ptt = 1'b0;
      d.relay = 1'b0;
      d.data_go = 1'b0;
      d.seq = ST_IDLE;
      taken = 1'b0;
      req = 1'b1;
    end
    d.pend = (q.pend & ~taken) | req;

    // Counter: a new event after a clear still counts.
    d.count = cnt_base;
    if (ev_take && cnt_active) begin
      d.count = cnt_base + 16'h0001;
      d.rearm = q.debounce;
    end

    // Diagnostic tones.
    unique case ({q.ctrl[CB_TONE_SPACE], q.ctrl[CB_TONE_MARK]})
      2'b11: begin
        d.tone_on = 1'b1;
        if (tif.tick_baud) begin
          d.tone_sp = ~q.tone_sp;
        end
      end
      2'b01: begin
        d.tone_on = 1'b1;
        d.tone_sp = 1'b0;
      end
      2'b10: begin
        d.tone_on = 1'b1;
        d.tone_sp = 1'b1;
      end
      2'b00: begin
        d.tone_on = 1'b0;
        d.tone_sp = 1'b0;
      end
    endcase

    // APB writes take effect in the access phase.
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: d.ctrl = pwdata[CTRL_W-1:0];
        ADDR_TIMING: begin
          d.quiet = pwdata[TM_QUIET_LSB +: 8];
          d.debounce = pwdata[TM_DEBOUNCE_LSB +: 8];
          d.power_s = pwdata[TM_POWER_LSB +: 8];
        end
        ADDR_TXDLY: d.txdly = pwdata[9:0];
        ADDR_SUPPLY: d.lvmin = pwdata[7:0];
        ADDR_PROF0: d.prof0 = pwdata;
        ADDR_PROF1: d.prof1 = pwdata;
        default: begin
        end
      endcase
    end

    // APB read data is captured in setup, so there are no wait states.
    d.ready = 1'b1;
    if (setup) begin
      d.slverr = 1'b0;
      d.rdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL: d.rdata[CTRL_W-1:0] = q.ctrl;
        ADDR_TIMING: begin
          d.rdata[TM_QUIET_LSB +: 8] = q.quiet;
          d.rdata[TM_DEBOUNCE_LSB +: 8] = q.debounce;
          d.rdata[TM_POWER_LSB +: 8] = q.power_s;
        end
        ADDR_TXDLY: d.rdata[9:0] = q.txdly;
        ADDR_SUPPLY: d.rdata[7:0] = q.lvmin;
        ADDR_PROF0: d.rdata = q.prof0;
        ADDR_PROF1: d.rdata = q.prof1;
        ADDR_STATUS: begin
          d.rdata[15:0] = q.count;
          d.rdata[ST_PROFILE] = q.profile;
          d.rdata[ST_BUSY] = busy;
          d.rdata[ST_FIX] = fix_ok;
          d.rdata[ST_INHIBIT] = inhibit;
          d.rdata[ST_PEND] = q.pend;
          d.rdata[ST_SEQ_LSB +: 5] = q.seq;
        end
        default: d.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign ptt_out = q.ptt;
  assign power_relay = q.relay;
  assign data_start = q.data_go;
  assign profile_sel = q.profile;
  assign profile_load = q.prof_load;
  assign tone_en = q.tone_on;
  assign tone_space = q.tone_sp;
endmodule

// file: rtl/trk_pkg.sv
// Constants, register map and sequencer states of the transmit gating block.
// Assumes a 100 MHz pclk; all times are derived from its period.
package trk_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  // One quiet-time unit is 1/64 second.
  localparam int unsigned Q64_NS = 15625000;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned BAUD_FAST = 1200;
  localparam int unsigned BAUD_SLOW = 300;
  localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned Q64_CYC = Q64_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned BAUD_FAST_CYC = SEC_CYC / BAUD_FAST;
  localparam int unsigned BAUD_SLOW_CYC = SEC_CYC / BAUD_SLOW;
  localparam logic [4:0] FIX_TIMEOUT_S = 5'h14;
  localparam logic [4:0] FIX_AGE_RST = 5'h15;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_TXDLY = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY = 8'h0c;
  localparam logic [7:0] ADDR_PROF0 = 8'h10;
  localparam logic [7:0] ADDR_PROF1 = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CB_CNT_EN = 0;
  localparam int CB_CNT_RST = 1;
  localparam int CB_PWR = 2;
  localparam int CB_LOWV = 3;
  localparam int CB_CDINV = 4;
  localparam int CB_SWDCD = 5;
  localparam int CB_PTTIN = 6;
  localparam int CB_TONE_MARK = 7;
  localparam int CB_TONE_SPACE = 8;
  localparam int CB_BAUD300 = 9;
  localparam int CB_EXTSQL = 10;
  localparam int CB_TX_GO = 11;
  localparam int CTRL_W = 11;
  localparam int TM_QUIET_LSB = 0;
  localparam int TM_DEBOUNCE_LSB = 8;
  localparam int TM_POWER_LSB = 16;
  localparam int PB_EN_LSB = 0;
  localparam int PB_OP_LSB = 4;
  localparam int PB_TXSW = 8;
  localparam int PB_ADC_THR_LSB = 16;
  localparam int PB_VOLT_THR_LSB = 24;
  localparam int C_ADC = 0;
  localparam int C_VOLT = 1;
  localparam int C_JMP = 2;
  localparam int C_FIX = 3;
  localparam int ST_PROFILE = 16;
  localparam int ST_BUSY = 17;
  localparam int ST_FIX = 18;
  localparam int ST_INHIBIT = 19;
  localparam int ST_PEND = 20;
  localparam int ST_SEQ_LSB = 24;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [7:0] QUIET_RST = 8'h00;
  localparam logic [7:0] DEBOUNCE_RST = 8'h00;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [9:0] TXDLY_RST = 10'h000;
  localparam logic [7:0] LVMIN_RST = 8'h00;
  localparam logic [31:0] PROF_RST = 32'h0000_0000;
  // Synchronisers start at the idle pin levels, so no false edge follows
  // reset: {carrier, squelch, event_n, switch, mic_n}.
  localparam logic [4:0] SYNC_RST = 5'h05;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_POWER = 5'b00010,
    ST_QUIET = 5'b00100,
    ST_KEY = 5'b01000,
    ST_SEND = 5'b10000
  } trk_seq_type;

endpackage

// file: rtl/trk_tick_div.sv
// Divider that makes one-cycle enables for ms, 1/64 s, s and baud rate.
// Assumes pclk and the asynchronous active-low presetn of the block.
module trk_tick_div #(
  parameter int unsigned MS_CYCLES = trk_pkg::MS_CYC,
  parameter int unsigned Q64_CYCLES = trk_pkg::Q64_CYC,
  parameter int unsigned SEC_CYCLES = trk_pkg::SEC_CYC,
  parameter int unsigned BAUD_FAST_CYCLES = trk_pkg::BAUD_FAST_CYC,
  parameter int unsigned BAUD_SLOW_CYCLES = trk_pkg::BAUD_SLOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  trk_tick_if.gen tif
);
  import trk_pkg::*;

  typedef struct packed {
    logic [31:0] ms;
    logic [31:0] q64;
    logic [31:0] sec;
    logic [31:0] baud;
    logic [3:0] ticks;
  } trk_div_type;

  trk_div_type q;
  trk_div_type d;
  logic [31:0] baud_end;

  always_comb begin
    d = q;
    baud_end = tif.baud_slow ? 32'(BAUD_SLOW_CYCLES - 1)
                             : 32'(BAUD_FAST_CYCLES - 1);
    d.ticks[0] = (q.ms == 32'(MS_CYCLES - 1));
    d.ticks[1] = (q.q64 == 32'(Q64_CYCLES - 1));
    d.ticks[2] = (q.sec == 32'(SEC_CYCLES - 1));
    d.ticks[3] = (q.baud >= baud_end);
    d.ms = d.ticks[0] ? 32'h0 : q.ms + 32'h1;
    d.q64 = d.ticks[1] ? 32'h0 : q.q64 + 32'h1;
    d.sec = d.ticks[2] ? 32'h0 : q.sec + 32'h1;
    d.baud = d.ticks[3] ? 32'h0 : q.baud + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.tick_ms = q.ticks[0];
  assign tif.tick_q64 = q.ticks[1];
  assign tif.tick_sec = q.ticks[2];
  assign tif.tick_baud = q.ticks[3];
endmodule

// file: rtl/trk_tick_if.sv
// Tick enables passed from the divider to the gating logic.
// Assumes both ends run on pclk.
interface trk_tick_if;
  logic tick_ms;
  logic tick_q64;
  logic tick_sec;
  logic tick_baud;
  logic baud_slow;
  modport gen (output tick_ms, output tick_q64, output tick_sec,
    output tick_baud, input baud_slow);
  modport use_side (input tick_ms, input tick_q64, input tick_sec,
    input tick_baud, output baud_slow);
endinterface

// file: verif/tb.sv
// Self-checking bench for the transmit gating block.
// Assumes shortened tick parameters and a behavioural radio model.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import trk_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic squelch_open_input = 1'b0, event_n = 1'b1, profile_switch = 1'b0;
  logic mic_ptt_n = 1'b1, carrier_detect_qualifier = 1'b0, fix_pulse = 1'b0;
  logic tx_request = 1'b0, car_lvl = 1'b0, slow = 1'b0;
  logic [7:0] supply_level = 8'hff, adc_level = 8'h00;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, ptt_out, power_relay, data_start, rerr;
  logic profile_sel, profile_load, tone_en, tone_space, carrier_in, tx_done;
  logic [3:0] bt [6] = '{4'h2, 4'h1, 4'h4, 4'h6, 4'ha, 4'h9};
  int failures = 0, check_count = 0;

  always #5 pclk = ~pclk;

  trk_gate #(.MS_CYCLES(10), .Q64_CYCLES(20), .SEC_CYCLES(100),
    .BAUD_FAST_CYCLES(8), .BAUD_SLOW_CYCLES(16)) dut (.*);
  trk_radio_model radio (.*);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1);
    @(posedge pclk);
  endtask

  // Waits on the falling edge for one output to reach a level.
  task automatic wt(input int s, input logic v, input int lim);
    logic x;
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      x = s == 0 ? ptt_out : s == 1 ? power_relay : s == 2 ? data_start
        : s == 3 ? profile_sel : tone_space;
      n++;
    end while (x !== v && n < lim);
    chk("wait_level", x, v);
    @(posedge pclk);
  endtask

  task automatic evt();
    event_n <= 1'b0;
    repeat (4) @(posedge pclk);
    event_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk("reset_value", rdata, 32'h0000_0000);
    end
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("status", rdata, 32'h0100_0000);
    fix_pulse <= 1'b1;
    @(posedge pclk);
    fix_pulse <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("fix", rdata[ST_FIX], 1);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk("unmapped", {rerr, rdata[30:0]}, 32'h8000_0000);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_CTRL, {26'h0, bt[i][3:2], 4'h0});
      car_lvl <= bt[i][1];
      carrier_detect_qualifier <= bt[i][0];
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk("busy", rdata[ST_BUSY], 6'h25 >> i & 1);
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0400);
    squelch_open_input <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("squelch", rdata[ST_BUSY], 1);
    squelch_open_input <= 1'b0;
    car_lvl <= 1'b0;
    carrier_detect_qualifier <= 1'b0;
    slow <= 1'b1;
    apb(1'b1, ADDR_TXDLY, 32'h0000_0003);
    apb(1'b1, ADDR_TIMING, 32'h0002_0002);
    apb(1'b1, ADDR_CTRL, 32'h0000_0804);
    wt(1, 1'b1, 5);
    wt(0, 1'b1, 400);
    wt(2, 1'b1, 50);
    wt(0, 1'b0, 100);
    chk("relay", power_relay, 0);
    slow <= 1'b0;
    apb(1'b1, ADDR_TIMING, 32'h0000_0300);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    evt();
    evt();
    repeat (40) @(posedge pclk);
    evt();
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("count", {rdata[28:24], rdata[20], rdata[15:0]}, 22'h02_0002);
    apb(1'b1, ADDR_PROF0, 32'h0000_0004);
    evt();
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("count", {rdata[28:24], rdata[20], rdata[15:0]}, 22'h02_0002);
    apb(1'b1, ADDR_PROF0, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0803);
    wt(0, 1'b1, 100);
    wt(0, 1'b0, 100);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("count", rdata[15:0], 0);
    supply_level <= 8'h10;
    apb(1'b1, ADDR_SUPPLY, 32'h0000_0080);
    apb(1'b1, ADDR_CTRL, 32'h0000_0008);
    tx_request <= 1'b1;
    @(posedge pclk);
    tx_request <= 1'b0;
    repeat (100) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("inhibit", {rdata[20:19], ptt_out}, 3'h6);
    supply_level <= 8'h80;
    wt(0, 1'b1, 100);
    wt(0, 1'b0, 100);
    apb(1'b1, ADDR_CTRL, 32'h0000_0040);
    mic_ptt_n <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h0000_0840);
    repeat (100) @(posedge pclk);
    chk("ptt", ptt_out, 0);
    mic_ptt_n <= 1'b1;
    wt(0, 1'b1, 50);
    wt(0, 1'b0, 100);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    adc_level <= 8'h41;
    apb(1'b1, ADDR_PROF1, 32'h0040_0111);
    wt(3, 1'b1, 120);
    wt(0, 1'b1, 20);
    apb(1'b1, ADDR_PROF0, 32'h0050_0001);
    wt(3, 1'b0, 120);
    wt(3, 1'b1, 120);
    adc_level <= 8'h40;
    wt(3, 1'b0, 120);
    repeat (250) @(posedge pclk);
    chk("profile", profile_sel, 0);
    apb(1'b1, ADDR_PROF1, 32'h0000_0044);
    repeat (150) @(posedge pclk);
    chk("profile", profile_sel, 0);
    profile_switch <= 1'b1;
    wt(3, 1'b1, 120);
    apb(1'b1, ADDR_PROF0, 32'h0000_0000);
    apb(1'b1, ADDR_PROF1, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CTRL, i ? 32'h0000_0380 : 32'h0000_0180);
      repeat (3) @(posedge pclk);
      chk("tone_en", tone_en, 1);
      wt(4, ~tone_space, i ? 17 : 9);
    end
    tally_and_finish();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
endmodule

// file: verif/trk_gate_properties.sv
// Port checker for the transmit gating block.
// Assumes it is bound to trk_gate and that settings arrive only over APB.
module trk_gate_properties
  import trk_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10,
  parameter int unsigned Q64_CYCLES = 20,
  parameter int unsigned SEC_CYCLES = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic carrier_in,
  input wire logic squelch_open_input,
  input wire logic mic_ptt_n,
  input wire logic carrier_detect_qualifier,
  input wire logic [7:0] supply_level,
  input wire logic ptt_out,
  input wire logic power_relay,
  input wire logic data_start,
  input wire logic profile_sel,
  input wire logic profile_load,
  input wire logic tone_en,
  input wire logic tone_space
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Shadow settings and elapsed-time counters
  // ****************************************************************
  logic [31:0] ctrl_q, tim_q, dly_q, lv_q;
  logic [15:0] free_q, key_q, rly_q;
  logic busy_w;

  // Channel busy as seen at the pins; the design sees the pin inputs two cycles later.
  assign busy_w = ctrl_q[CB_SWDCD] ? carrier_detect_qualifier
    : ctrl_q[CB_EXTSQL] ? squelch_open_input
    : carrier_in ^ ctrl_q[CB_CDINV];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      tim_q <= '0;
      dly_q <= '0;
      lv_q <= '0;
      free_q <= '0;
      key_q <= '0;
      rly_q <= '0;
    end else begin
      if (psel && penable && pwrite && pready) begin
        if (paddr == ADDR_CTRL) ctrl_q <= pwdata;
        if (paddr == ADDR_TIMING) tim_q <= pwdata;
        if (paddr == ADDR_TXDLY) dly_q <= pwdata;
        if (paddr == ADDR_SUPPLY) lv_q <= pwdata;
      end
      free_q <= busy_w ? 16'h0000 : free_q + 16'h0001;
      key_q <= ptt_out ? key_q + 16'h0001 : 16'h0000;
      rly_q <= power_relay ? rly_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NO_WAIT: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (psel && penable && paddr > ADDR_STATUS
    |-> pslverr) else $error("unmapped access without error");
  AST_TXDLY: assert property (data_start |-> ptt_out
    && key_q + MS_CYCLES >= dly_q[9:0] * MS_CYCLES
    && key_q <= dly_q[9:0] * MS_CYCLES + 2) else $error("data start time");
  AST_POWER_WAIT: assert property ($rose(ptt_out) && ctrl_q[CB_PWR]
    |-> power_relay && rly_q + SEC_CYCLES >= tim_q[23:16] * SEC_CYCLES)
    else $error("keyed before power-up time");
  AST_RELAY_DROP: assert property ($fell(ptt_out) |-> !power_relay)
    else $error("relay left on after unkey");
  AST_QUIET: assert property ($rose(ptt_out)
    |-> free_q + Q64_CYCLES >= tim_q[7:0] * Q64_CYCLES)
    else $error("keyed before quiet time");
  AST_BUSY_BLOCK: assert property (busy_w [*5] |=> !$rose(ptt_out))
    else $error("keyed on busy channel");
  AST_LOWV: assert property ((ctrl_q[CB_LOWV]
    && supply_level < lv_q[7:0]) [*3] |=> !ptt_out && !power_relay)
    else $error("keyed at low supply");
  AST_MIC_HOLD: assert property ((ctrl_q[CB_PTTIN] && !mic_ptt_n) [*5]
    |=> !$rose(ptt_out)) else $error("keyed while microphone held");
  AST_PROF_LOAD: assert property ($changed(profile_sel) |-> profile_load)
    else $error("profile changed without load");
  AST_TONE: assert property ((ctrl_q[CB_TONE_MARK]
    && ctrl_q[CB_TONE_SPACE]) [*3] |=> tone_en ##[1:20]
    $changed(tone_space)) else $error("tones not alternating");

  cover property ($rose(data_start));
  cover property ($changed(profile_sel));
  cover property (psel && penable && pslverr);
endmodule

bind trk_gate trk_gate_properties #(.MS_CYCLES(MS_CYCLES),
  .Q64_CYCLES(Q64_CYCLES), .SEC_CYCLES(SEC_CYCLES)) u_props (.*);

// file: verif/trk_radio_model.sv
// Behavioural radio: carrier pin level and end-of-frame answer.
// Assumes pclk and presetn of the block; the bench sets carrier and pace.
module trk_radio_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_start,
  input wire logic car_lvl,
  input wire logic slow,
  output logic carrier_in,
  output logic tx_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned left;

  assign carrier_in = car_lvl;

  // The frame ends a short or a long time after data starts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (left == 1);
      if (data_start) left <= slow ? 60 : 3;
      else if (left != 0) left <= left - 1;
    end
  end
endmodule
